// ==== src/tpwm_pkg.sv ====
/*
  Shared constants and carrier types for the timer pulse output block:
  register map, field positions, reset values, modes and APB carriers.
  Assumes a 32-bit APB with one aligned word per register.
*/
package tpwm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TPWM_OFF_TIMER_CTRL = 8'h00;
  localparam logic [7:0] TPWM_OFF_OUT_CTRL = 8'h04;
  localparam logic [7:0] TPWM_OFF_ONESHOT_CTRL = 8'h08;
  localparam logic [7:0] TPWM_OFF_COMPARE_A = 8'h0C;
  localparam logic [7:0] TPWM_OFF_COMPARE_B = 8'h10;
  localparam logic [7:0] TPWM_OFF_CAPTURE = 8'h14;
  localparam logic [7:0] TPWM_OFF_COUNTER = 8'h18;
  localparam logic [7:0] TPWM_OFF_STATUS = 8'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int TPWM_TC_RUN = 0;
  localparam int TPWM_TC_PRESC_LO = 1;
  localparam int TPWM_TC_CLRB = 5;
  localparam int TPWM_TC_MODE_A_LO = 6;
  localparam int TPWM_TC_MODE_B_LO = 8;
  localparam int TPWM_OC_EN_A = 0;
  localparam int TPWM_OC_ALV_A = 1;
  localparam int TPWM_OC_EN_B = 2;
  localparam int TPWM_OC_ALV_B = 3;
  localparam int TPWM_OS_TRIG_LO = 0;
  localparam int TPWM_OS_RST_LO = 2;
  localparam int TPWM_ST_MATCH_LO = 0;
  localparam int TPWM_ST_CAPTURE = 2;
  localparam int TPWM_ST_OVERFLOW = 3;

  // ----------------------------------------------------------------
  // reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [15:0] TPWM_CMP_RESET = 16'hFFFF;
  localparam logic [3:0] TPWM_PRESC_MAX = 4'h8;
  localparam logic [10:0] TPWM_PRESC_FULL_MASK = 11'h7FF;
  localparam logic [1:0] TPWM_MIN_PHASE_CLKS = 2'h3;

  // output mode of one pulse channel
  typedef enum logic [1:0] {
    TPWM_MODE_FIXED,
    TPWM_MODE_PWM,
    TPWM_MODE_PPG,
    TPWM_MODE_ONESHOT
  } tpwm_mode_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tpwm_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tpwm_apb_rsp_t;

endpackage

// ==== src/tpwm_timer_out.sv ====
/*
  Timer pulse output block: 16-bit up counter with prescaler, two compare
  registers, PWM / PPG / one-shot pulse outputs and both-edge capture.
  Assumes a single 125 MHz clock and an APB master on the same clock;
  the capture input is asynchronous and is synchronised here.
*/
`timescale 1ns/100ps

// What this block does
// - PWM period is one full 16-bit counter wrap; width is compare count.
// - output enable passes the waveform, otherwise the pin is held fixed.
// - PWM output changes at most once per period on a compare match.
// - compare set below counter in PWM gives a full duty period.
// - stopping the counter in PWM mode drives the inactive level.
// - disabled output shows inverse of active level select.
// - PPG period is compare_b plus one, width compare_a count clocks.
// - PPG drives only wave_out_a and needs clear on compare_b set.
// - PPG output changes at most once per period from compare_a.
// - compare_a at or below counter before match gives full duty.
// - compare_b below counter stretches period to a full wrap.
// - compare_b lowered before a match holds active until that match.
// - stopping the counter in PPG mode drives the inactive level.
// - one-shot trigger drives active; compare match returns inactive.
// - one-shot reset forces inactive until the next trigger.
// - the two one-shot channels work independently.
// - stopping the counter in one-shot mode holds the output level.
// - clear on match gives repeated match flags every compare plus one.
// - both edges of the capture input copy the counter to capture.
// - capture input phases under four clocks are ignored.
// - PWM duty settable in steps of one in 65536 on both outputs.
module tpwm_timer_out #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire tpwm_pkg::tpwm_apb_req_t apb_req,
  output tpwm_pkg::tpwm_apb_rsp_t apb_rsp,
  input wire logic edge_capture_input,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic irq_match_a,
  output logic irq_match_b,
  output logic irq_capture
);
  import tpwm_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic count_run;
    logic [3:0] presc_sel;
    logic clear_on_compare_b;
    logic [1:0][1:0] mode;
    logic [1:0] output_enable_bit;
    logic [1:0] active_level_select;
    logic [CNT_W-1:0] compare_a;
    logic [CNT_W-1:0] compare_b;
    logic [CNT_W-1:0] capture_reg;
    logic [CNT_W-1:0] main_counter;
    logic [10:0] div;
    logic [1:0] act;
    logic [1:0] done;
    logic [3:0] flags;
    logic [2:0] sync;
    logic filt;
    logic [1:0] fcnt;
    logic [1:0] wave;
    logic [31:0] prdata;
    logic pslverr;
  } tpwm_state_t;

  tpwm_state_t s_q;
  tpwm_state_t s_d;

  // mask of divider bits that must all be set for one count clock
  function automatic logic [10:0] presc_mask(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > TPWM_PRESC_MAX) ? TPWM_PRESC_MAX : sel;
    return TPWM_PRESC_FULL_MASK >> (TPWM_PRESC_MAX - s);
  endfunction

  // pin level for a channel from mode, active flag and control bits
  function automatic logic pin_level(input logic [1:0] m, input logic act,
                                     input logic en, input logic alv);
    logic lvl;
    lvl = ~alv;
    if (en)
    begin
      unique case (tpwm_mode_t'(m))
        TPWM_MODE_PWM, TPWM_MODE_PPG: lvl = act ? ~alv : alv;
        TPWM_MODE_ONESHOT: lvl = act ? alv : ~alv;
        TPWM_MODE_FIXED: lvl = ~alv;
      endcase
    end
    return lvl;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic tick;
  logic cnt_tick;
  logic ovf;
  logic [1:0] match;
  logic [1:0] trig;
  logic [1:0] ost_rst;
  logic cap_evt;
  logic [3:0] st_clr;
  logic [CNT_W-1:0] nxt;
  logic [1:0] mode_c;

  // whole block next-state logic
  always_comb
  begin
    s_d = s_q;
    mode_c = 2'h0;
    setup = apb_req.psel & ~apb_req.penable;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    trig = 2'h0;
    ost_rst = 2'h0;
    st_clr = 4'h0;
    cap_evt = 1'b0;

    // register writes take effect at the access edge
    if (wr)
    begin
      unique case (apb_req.paddr)
        TPWM_OFF_TIMER_CTRL:
        begin
          s_d.count_run = apb_req.pwdata[TPWM_TC_RUN];
          s_d.presc_sel = apb_req.pwdata[TPWM_TC_PRESC_LO +: 4];
          s_d.clear_on_compare_b = apb_req.pwdata[TPWM_TC_CLRB];
          s_d.mode[0] = apb_req.pwdata[TPWM_TC_MODE_A_LO +: 2];
          s_d.mode[1] = apb_req.pwdata[TPWM_TC_MODE_B_LO +: 2];
        end
        TPWM_OFF_OUT_CTRL:
        begin
          s_d.output_enable_bit[0] = apb_req.pwdata[TPWM_OC_EN_A];
          s_d.active_level_select[0] = apb_req.pwdata[TPWM_OC_ALV_A];
          s_d.output_enable_bit[1] = apb_req.pwdata[TPWM_OC_EN_B];
          s_d.active_level_select[1] = apb_req.pwdata[TPWM_OC_ALV_B];
        end
        TPWM_OFF_ONESHOT_CTRL:
        begin
          trig = apb_req.pwdata[TPWM_OS_TRIG_LO +: 2];
          ost_rst = apb_req.pwdata[TPWM_OS_RST_LO +: 2];
        end
        TPWM_OFF_COMPARE_A: s_d.compare_a = apb_req.pwdata[CNT_W-1:0];
        TPWM_OFF_COMPARE_B: s_d.compare_b = apb_req.pwdata[CNT_W-1:0];
        TPWM_OFF_STATUS: st_clr = apb_req.pwdata[3:0];
        default: ;
      endcase
    end

    // read data and error are captured in the setup cycle
    if (setup)
    begin
      s_d.prdata = 32'h0000_0000;
      s_d.pslverr = 1'b0;
      unique case (apb_req.paddr)
        TPWM_OFF_TIMER_CTRL:
        begin
          s_d.prdata[TPWM_TC_RUN] = s_q.count_run;
          s_d.prdata[TPWM_TC_PRESC_LO +: 4] = s_q.presc_sel;
          s_d.prdata[TPWM_TC_CLRB] = s_q.clear_on_compare_b;
          s_d.prdata[TPWM_TC_MODE_A_LO +: 2] = s_q.mode[0];
          s_d.prdata[TPWM_TC_MODE_B_LO +: 2] = s_q.mode[1];
        end
        TPWM_OFF_OUT_CTRL:
        begin
          s_d.prdata[TPWM_OC_EN_A] = s_q.output_enable_bit[0];
          s_d.prdata[TPWM_OC_ALV_A] = s_q.active_level_select[0];
          s_d.prdata[TPWM_OC_EN_B] = s_q.output_enable_bit[1];
          s_d.prdata[TPWM_OC_ALV_B] = s_q.active_level_select[1];
        end
        TPWM_OFF_ONESHOT_CTRL: ; // trigger bits read as zero
        TPWM_OFF_COMPARE_A: s_d.prdata[CNT_W-1:0] = s_q.compare_a;
        TPWM_OFF_COMPARE_B: s_d.prdata[CNT_W-1:0] = s_q.compare_b;
        TPWM_OFF_CAPTURE: s_d.prdata[CNT_W-1:0] = s_q.capture_reg;
        TPWM_OFF_COUNTER: s_d.prdata[CNT_W-1:0] = s_q.main_counter;
        TPWM_OFF_STATUS: s_d.prdata[3:0] = s_q.flags;
        default: s_d.pslverr = 1'b1; // unmapped address
      endcase
    end

    // prescaler: free divider, one count clock pulse per wrap of the mask
    s_d.div = s_q.div + 11'h001;
    tick = &(s_q.div | ~presc_mask(s_q.presc_sel));
    cnt_tick = tick & s_q.count_run;

    // counter step, with optional clear after reaching compare_b
    // interval clear
    if (s_q.clear_on_compare_b && s_q.main_counter == s_q.compare_b)
      nxt = '0;
    else
      nxt = s_q.main_counter + 1'b1;
    if (cnt_tick)
      s_d.main_counter = nxt;

    match[0] = cnt_tick && (nxt == s_q.compare_a);
    match[1] = cnt_tick && (nxt == s_q.compare_b);
    ovf = cnt_tick && (nxt == '0);

    // per-channel waveform state
    for (int i = 0; i < 2; i++)
    begin
      mode_c = s_q.mode[i];
      if (i == 1 && tpwm_mode_t'(mode_c) == TPWM_MODE_PPG)
        mode_c = TPWM_MODE_FIXED;
      unique case (tpwm_mode_t'(mode_c))
        TPWM_MODE_PWM, TPWM_MODE_PPG:
        begin
          if (!s_q.count_run)
          begin
            s_d.act[i] = 1'b1;
            s_d.done[i] = 1'b0;
          end
          else
          begin
            if (ovf)
            begin
              s_d.act[i] = 1'b1;
              s_d.done[i] = 1'b0;
            end
            if (match[i] && !s_q.done[i])
            begin
              s_d.act[i] = 1'b0;
              s_d.done[i] = 1'b1;
            end
          end
        end
        TPWM_MODE_ONESHOT:
        begin
          if (match[i])
            s_d.act[i] = 1'b0;
          if (ost_rst[i])
            s_d.act[i] = 1'b0;
          if (trig[i])
            s_d.act[i] = 1'b1;
          s_d.done[i] = 1'b0;
        end
        TPWM_MODE_FIXED:
        begin
          s_d.act[i] = 1'b0;
          s_d.done[i] = 1'b0;
        end
      endcase
      s_d.wave[i] = pin_level(mode_c, s_d.act[i],
                              s_q.output_enable_bit[i],
                              s_q.active_level_select[i]);
    end

    // capture input: three stage synchroniser
    s_d.sync = {s_q.sync[1:0], edge_capture_input};
    if (s_q.sync[1] == s_q.sync[2] && s_q.sync[2] != s_q.filt)
    begin
      if (s_q.fcnt == TPWM_MIN_PHASE_CLKS - 2'h1)
      begin
        s_d.filt = s_q.sync[2];
        s_d.fcnt = 2'h0;
        cap_evt = 1'b1;
      end
      else
        s_d.fcnt = s_q.fcnt + 2'h1;
    end
    else
      s_d.fcnt = 2'h0;
    if (cap_evt)
      s_d.capture_reg = s_q.main_counter;

    // sticky status, set wins over write one to clear
    // match flag per compare
    s_d.flags = s_q.flags & ~st_clr;
    s_d.flags[TPWM_ST_MATCH_LO +: 2] = s_d.flags[TPWM_ST_MATCH_LO +: 2]
                                       | match;
    s_d.flags[TPWM_ST_CAPTURE] = s_d.flags[TPWM_ST_CAPTURE] | cap_evt;
    s_d.flags[TPWM_ST_OVERFLOW] = s_d.flags[TPWM_ST_OVERFLOW] | ovf;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // all state under asynchronous reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.compare_a <= TPWM_CMP_RESET;
      s_q.compare_b <= TPWM_CMP_RESET;
      s_q.wave <= 2'h3; // disabled, select 0: pins high
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero wait state apb answer and pin drive
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = s_q.pslverr;
  assign apb_rsp.prdata = s_q.prdata;
  assign wave_out_a = s_q.wave[0];
  assign wave_out_b = s_q.wave[1];
  assign irq_match_a = s_q.flags[TPWM_ST_MATCH_LO];
  assign irq_match_b = s_q.flags[TPWM_ST_MATCH_LO + 1];
  assign irq_capture = s_q.flags[TPWM_ST_CAPTURE];

endmodule

// ==== test/tpwm_chk.sv ====
/* checker for the timer pulse output block: pin levels against shadowed
   control writes. assumes zero-wait apb and registered pins. */
`timescale 1ns/100ps
module tpwm_chk #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire tpwm_pkg::tpwm_apb_req_t apb_req,
  input wire tpwm_pkg::tpwm_apb_rsp_t apb_rsp,
  input wire logic wave_out_a,
  input wire logic wave_out_b,
  input wire logic irq_match_a
);
  import tpwm_pkg::*;
  logic wr, wr_q, wr2_q, quiet, run, wr_os, wr_st;
  logic [9:0] tc_q;
  logic [3:0] oc_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // write strobe and quiet window after any write
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp.pready;
  assign quiet = !wr_q && !wr2_q;
  assign run = tc_q[TPWM_TC_RUN];
  assign wr_os = wr && apb_req.paddr == TPWM_OFF_ONESHOT_CTRL;
  assign wr_st = wr && apb_req.paddr == TPWM_OFF_STATUS;
  // shadow of the control registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {tc_q, oc_q, wr_q, wr2_q} <= '0;
    else
    begin
      wr_q <= wr;
      wr2_q <= wr_q;
      if (wr && apb_req.paddr == TPWM_OFF_TIMER_CTRL)
        tc_q <= apb_req.pwdata[9:0];
      if (wr && apb_req.paddr == TPWM_OFF_OUT_CTRL)
        oc_q <= apb_req.pwdata[3:0];
    end
  end
  property p_dis_a;
    !oc_q[0] && quiet |-> wave_out_a == !oc_q[1];
  endproperty
  a_dis_a: assert property (p_dis_a)
    else $error("disabled level a wrong");
  property p_dis_b;
    !oc_q[2] && quiet |-> wave_out_b == !oc_q[3];
  endproperty
  a_dis_b: assert property (p_dis_b)
    else $error("disabled level b wrong");
  property p_stop_a;
    !run && quiet && (tc_q[7:6] == TPWM_MODE_PWM || tc_q[7:6] == TPWM_MODE_PPG)
      |-> wave_out_a == !oc_q[1];
  endproperty
  a_stop_a: assert property (p_stop_a)
    else $error("stopped level a wrong");
  property p_stop_b;
    !run && quiet && tc_q[9:8] == TPWM_MODE_PWM |-> wave_out_b == !oc_q[3];
  endproperty
  a_stop_b: assert property (p_stop_b)
    else $error("stopped level b wrong");
  property p_os_hold;
    !run && quiet && tc_q[7:6] == TPWM_MODE_ONESHOT |-> $stable(wave_out_a);
  endproperty
  a_os_hold: assert property (p_os_hold)
    else $error("one-shot level moved while stopped");
  property p_os_trig;
    wr_os && apb_req.pwdata[0] && tc_q[7:6] == TPWM_MODE_ONESHOT && !run
      && oc_q[0] |-> ##2 wave_out_a == oc_q[1];
  endproperty
  a_os_trig: assert property (p_os_trig)
    else $error("trigger did not go active");
  property p_os_rst;
    wr_os && apb_req.pwdata[2] && !apb_req.pwdata[0]
      && tc_q[7:6] == TPWM_MODE_ONESHOT |-> ##2 wave_out_a == !oc_q[1];
  endproperty
  a_os_rst: assert property (p_os_rst)
    else $error("reset did not go inactive");
  property p_irq_hold;
    $fell(irq_match_a) |-> $past(wr_st && apb_req.pwdata[0]);
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("match flag a dropped without clear");
endmodule

bind tpwm_timer_out tpwm_chk #(.CNT_W(CNT_W)) chk (
  .clk(clk),
  .rst_n(rst_n),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .wave_out_a(wave_out_a),
  .wave_out_b(wave_out_b),
  .irq_match_a(irq_match_a)
);

// ==== test/tpwm_load.sv ====
/* load on one pulse pin: counts rises, last high width, last period.
   assumes a pin sampled on the system clock. */
`timescale 1ns/100ps
module tpwm_load (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wave,
  output logic [31:0] rises_q,
  output logic [31:0] hi_q,
  output logic [31:0] per_q
);
  logic prev_q;
  logic [31:0] run_q, since_q;
  // measure high phase and rise to rise spacing in clocks
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      {prev_q, run_q, since_q, rises_q, hi_q, per_q} <= '0;
    else
    begin
      prev_q <= wave;
      since_q <= (wave && !prev_q) ? 32'h1 : since_q + 32'h1;
      run_q <= (wave && !prev_q) ? 32'h1 : run_q + 32'h1;
      if (wave && !prev_q)
      begin
        rises_q <= rises_q + 32'h1;
        per_q <= since_q;
      end
      if (!wave && prev_q)
        hi_q <= run_q;
    end
  end
endmodule

// ==== test/tb_timer0_pwm_ppg_oneshot_output.sv ====
/* testbench: ppg table, stop levels, interval, one-shot and capture.
   assumes tpwm_pkg, the pin load model and the bound checker. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_timer0_pwm_ppg_oneshot_output;
  import tpwm_pkg::*;
  typedef struct packed
  {
    logic [15:0] ca;
    logic [15:0] cb;
    logic [31:0] hi;
    logic [31:0] per;
  } tpwm_row_t;
  logic clk = 0, rst_n = 0, cap = 0, err, wa, wb, ima, imb, icap;
  tpwm_apb_req_t req = '0;
  tpwm_apb_rsp_t rsp;
  logic [31:0] rd, c1, rises_a, hi_a, per_a;
  int errors = 0, n_checks = 0, cyc = 0, t0;
  // compares kept in range, cb never falling
  tpwm_row_t rows[3] = '{'{16'h1, 16'h1, 32'd8, 32'd16},
    '{16'h3, 16'h3, 32'd24, 32'd32}, '{16'h2, 16'h5, 32'd16, 32'd48}};
  always #4 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  tpwm_timer_out dut (.clk(clk), .rst_n(rst_n), .apb_req(req),
    .apb_rsp(rsp), .edge_capture_input(cap), .wave_out_a(wa),
    .wave_out_b(wb), .irq_match_a(ima), .irq_match_b(imb),
    .irq_capture(icap));
  tpwm_load load_a (.clk(clk), .rst_n(rst_n), .wave(wa),
    .rises_q(rises_a), .hi_q(hi_a), .per_q(per_a));
  // one apb transfer, released after pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1)
      @(posedge clk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial
  begin
    step(40000);
    errors++;
    conclude();
  end
  // main sequence
  initial
  begin
    step(10);
    rst_n <= 1'b1;
    step(1);
    `CHK(wa, 1'b1)
    apb(0, TPWM_OFF_COMPARE_A, 0);
    `CHK(rd, 32'h0000FFFF)
    apb(0, 8'h20, 0);
    `CHK(err, 1'b1)
    apb(1, TPWM_OFF_OUT_CTRL, 32'h1);
    foreach (rows[i])
    begin
      apb(1, TPWM_OFF_TIMER_CTRL, 0);
      apb(1, TPWM_OFF_COMPARE_A, 32'(rows[i].ca));
      apb(1, TPWM_OFF_COMPARE_B, 32'(rows[i].cb));
      apb(1, TPWM_OFF_TIMER_CTRL, 32'hA1);
      t0 = rises_a + 3;
      for (int k = 0; k < 999 && rises_a < t0; k++) step(1);
      `CHK(hi_a, rows[i].hi)
      `CHK(per_a, rows[i].per)
    end
    apb(1, TPWM_OFF_OUT_CTRL, 32'hD);
    apb(1, TPWM_OFF_TIMER_CTRL, 32'hA0);
    step(3);
    `CHK(wa, 1'b1)
    apb(1, TPWM_OFF_TIMER_CTRL, 32'h140);
    step(3);
    `CHK(wa, 1'b1)
    `CHK(wb, 1'b0)
    apb(1, TPWM_OFF_COMPARE_B, 32'h7);
    apb(1, TPWM_OFF_TIMER_CTRL, 32'h21);
    // drop flags left from the ppg rows so the first wait is real
    apb(1, TPWM_OFF_STATUS, 32'hF);
    for (int k = 0; k < 200 && imb !== 1'b1; k++) step(1);
    t0 = cyc;
    apb(1, TPWM_OFF_STATUS, 32'hF);
    for (int k = 0; k < 200 && imb !== 1'b1; k++) step(1);
    `CHK(cyc - t0, 64)
    `CHK(ima, 1'b1)
    cap <= 1'b1;
    step(2);
    cap <= 1'b0;
    step(20);
    `CHK(icap, 1'b0)
    cap <= 1'b1;
    step(20);
    `CHK(icap, 1'b1)
    apb(0, TPWM_OFF_CAPTURE, 0);
    c1 = rd;
    step(50);
    apb(0, TPWM_OFF_CAPTURE, 0);
    `CHK(rd, c1)
    apb(1, TPWM_OFF_OUT_CTRL, 32'hF);
    apb(1, TPWM_OFF_TIMER_CTRL, 32'h3E0);
    // trigger and reset in separate writes
    apb(1, TPWM_OFF_ONESHOT_CTRL, 32'h8);
    apb(1, TPWM_OFF_ONESHOT_CTRL, 32'h1);
    step(2);
    `CHK(wa, 1'b1)
    `CHK(wb, 1'b0)
    step(40);
    `CHK(wa, 1'b1)
    apb(1, TPWM_OFF_TIMER_CTRL, 32'h3E1);
    for (int k = 0; k < 100 && wa !== 1'b0; k++) step(1);
    step(60);
    `CHK(wa, 1'b0)
    apb(1, TPWM_OFF_ONESHOT_CTRL, 32'h1);
    apb(1, TPWM_OFF_ONESHOT_CTRL, 32'h4);
    step(60);
    `CHK(wa, 1'b0)
    apb(1, TPWM_OFF_OUT_CTRL, 32'h2);
    step(3);
    `CHK(wa, 1'b0)
    conclude();
  end
endmodule
